// ---- hw/bbs_pkg.sv ----
// Purpose: shared constants and types for the battery-backed sleep controller
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes: byte offsets, control bit positions, event bits and reset values
package bbs_pkg;
	localparam int ADDR_W = 12;
	localparam int MEM_WORDS = 64;
	localparam int MEM_AW = 6;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_MATCH0 = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_MATCH1 = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_LOAD = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_CTL = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_MASK = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_RAW = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_MASKED = 12'h01c;
	localparam logic [ADDR_W-1:0] OFS_CLEAR = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_TRIM = 12'h024;
	localparam logic [ADDR_W-1:0] OFS_PINS = 12'h028;
	localparam logic [ADDR_W-1:0] OFS_MEM_LO = 12'h030;
	localparam logic [ADDR_W-1:0] OFS_MEM_HI = 12'h12c;

	// control register bits
	localparam int CTL_RUN = 0;
	localparam int CTL_REQ = 1;
	localparam int CTL_REFSEL = 2;
	localparam int CTL_MATCHWAKE = 3;
	localparam int CTL_PINWAKE = 4;
	localparam int CTL_LOW_BATT_FLAG = 5;
	localparam int CTL_CLKEN = 6;
	localparam int CTL_ABORT = 7;
	localparam logic [31:0] CTL_WMASK = 32'h0000_00ff;

	// event bits, shared by raw, mask, masked and clear registers
	localparam int EV_W = 4;
	localparam int EV_MATCH0 = 0;
	localparam int EV_MATCH1 = 1;
	localparam int EV_LOW_BATT_FLAG = 2;
	localparam int EV_PIN = 3;

	// status pin register bits
	localparam int PIN_WAKE = 0;
	localparam int PIN_CUT = 1;
	localparam int PIN_ASLEEP = 2;

	// reset values
	localparam logic [31:0] RST_MATCH = 32'hffff_ffff;
	localparam logic [31:0] RST_LOAD = 32'hffff_ffff;
	localparam logic [31:0] RST_CTL = 32'h8000_0000;
	localparam logic [31:0] RST_TRIM = 32'h0000_7fff;

	// time base
	localparam int PRE_W = 16;
	localparam logic [PRE_W-1:0] PRE_NOMINAL = 16'h7fff;
	localparam int TRIM_IDX_W = 6;
	localparam int XDIV_W = 7;
	localparam logic [XDIV_W-1:0] XDIV_LAST = 7'h7f;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {BBS_AWAKE, BBS_CUT} bbs_pwr_t;
endpackage

// ---- hw/bbs_mem_if.sv ----
// Purpose: port bundle between the controller and its retained word store
// Assumes: one access per cycle, read data one cycle after request
// Notes: strobes select byte lanes on writes
`timescale 1ns/1ps
`default_nettype none
interface bbs_mem_if;
	import bbs_pkg::*;
	logic en;
	logic we;
	logic [MEM_AW-1:0] addr;
	logic [31:0] wdata;
	logic [3:0] strb;
	logic [31:0] rdata;
	modport ctl (output en, output we, output addr, output wdata, output strb, input rdata);
	modport mem (input en, input we, input addr, input wdata, input strb, output rdata);
endinterface
`default_nettype wire

// ---- hw/bbs_mem.sv ----
// Purpose: 64 retained 32-bit words with registered read data
// Assumes: contents survive power cut and system reset; only the power-on reset clears them
// Notes: clock enable low freezes contents and read data
`timescale 1ns/1ps
`default_nettype none
module bbs_mem
	import bbs_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic ce,
	bbs_mem_if.mem port
);
	typedef struct packed {
		logic [MEM_WORDS-1:0][31:0] words;
		logic [31:0] rdata;
	} bbs_mem_state_t;

	bbs_mem_state_t s_r;
	bbs_mem_state_t s_nxt;

	// byte-lane write, read returns the old word
	always_comb begin
		s_nxt = s_r;
		if (port.en) begin
			s_nxt.rdata = s_r.words[port.addr];
			if (port.we) begin
				for (int b = 0; b < 4; b++) begin
					if (port.strb[b])
						s_nxt.words[port.addr][8*b +: 8] = port.wdata[8*b +: 8];
				end
			end
		end
	end

	// only the power-on reset clears the store
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			s_r <= '0;
		else if (ce)
			s_r <= s_nxt;
	end

	assign port.rdata = s_r.rdata;
endmodule
`default_nettype wire

// ---- hw/bbs_top.sv ----
// Purpose: battery-backed sleep controller with seconds counter, matches and retained words
// Assumes: AXI4-Lite slave on clock; ref_tick and xtal_tick are one-cycle pulses of the slow references
// Notes: rst_b is the cold power-on; sys_reset_req only acts when counting and pin wake are off
// Notes on behaviour
// - compare backup voltage against low threshold
// - low-battery flag set when detection enabled
// - abort power-down on low battery
// - no battery check while powered down
// - 32-bit seconds counter advancing each second
// - predivider counts reference ticks, trim every 64
// - larger trim slows, smaller speeds up
// - two match registers compared against counter
// - counter runs only when enabled; load immediate
// - counting continues regardless of power state
// - 64 retained read/write words
// - power-cut output asserted low, released on wake
// - wake on pin or match when enabled
// - wake condition stays pending after power-up
// - three event kinds ORed into one line
// - per-event mask; write one clears event
// - match masks at event mask bits 1:0
// - reference select picks direct or crystal/128
// - clock enable bit kept through power-down
// - control codes start match, pin, both wake
// - reset on power-on or qualified system reset
`timescale 1ns/1ps
`default_nettype none
module bbs_top
	import bbs_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic sys_reset_req,
	input wire logic ref_tick,
	input wire logic xtal_tick,
	input wire logic wake_n,
	input wire logic vbat_low,
	input wire logic power_cut_in,
	output logic power_cut_out_n,
	output logic power_cut_oe_n,
	output logic irq,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_hold;
		logic [ADDR_W-1:0] aw_addr;
		logic w_hold;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic rd_pend;
		logic [ADDR_W-1:0] rd_addr;
		logic [31:0] count;
		logic [31:0] match0;
		logic [31:0] match1;
		logic [31:0] load;
		logic [31:0] ctl;
		logic [31:0] trim;
		logic [EV_W-1:0] mask;
		logic [EV_W-1:0] raw;
		logic [PRE_W-1:0] prediv;
		logic [TRIM_IDX_W-1:0] sec_idx;
		logic [XDIV_W-1:0] xdiv;
		logic [1:0] eq_prev;
		logic wake_prev;
		bbs_pwr_t pwr;
		logic cut_n;
		logic cut_oe_n;
		logic irq;
	} bbs_state_t;

	localparam bbs_state_t STATE_RST = '{
		awready: 1'b1, wready: 1'b1, arready: 1'b1,
		bresp: RESP_OKAY, rresp: RESP_OKAY,
		match0: RST_MATCH, match1: RST_MATCH, load: RST_LOAD,
		ctl: RST_CTL, trim: RST_TRIM, prediv: PRE_NOMINAL,
		wake_prev: 1'b1, pwr: BBS_AWAKE, cut_n: 1'b1, cut_oe_n: 1'b1,
		default: '0
	};

	bbs_state_t s_r;
	bbs_state_t s_nxt;
	bbs_mem_if mem_bus ();

	// merge a write into a register under the byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				res[8*b +: 8] = data[8*b +: 8];
		end
		return res;
	endfunction

	// true for a word address inside the retained store window
	function automatic logic in_mem(input logic [ADDR_W-1:0] a);
		return (a >= OFS_MEM_LO) && (a <= OFS_MEM_HI) && (a[1:0] == 2'h0);
	endfunction

	// word index of a retained store address
	function automatic logic [MEM_AW-1:0] mem_index(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] rel;
		rel = a - OFS_MEM_LO;
		return rel[MEM_AW+1:2];
	endfunction

	// mapped register or store word; misaligned and gaps answer with an error
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return (a[1:0] == 2'h0) && ((a <= OFS_PINS) || in_mem(a));
	endfunction

	logic do_write;
	logic do_read;
	logic ref_pulse;
	logic sec_pulse;
	logic [1:0] eq_now;
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] ev_clr;
	logic batt_low_now;
	logic wake_asserted;
	logic [31:0] wr_val;

	always_comb begin
		s_nxt = s_r;
		ev_set = '0;
		ev_clr = '0;
		wr_val = '0;

		// write channel: address and data taken in either order
		if (awvalid && s_r.awready) begin
			s_nxt.aw_hold = 1'b1;
			s_nxt.aw_addr = awaddr;
		end
		if (wvalid && s_r.wready) begin
			s_nxt.w_hold = 1'b1;
			s_nxt.w_data = wdata;
			s_nxt.w_strb = wstrb;
		end
		if (s_r.bvalid && bready)
			s_nxt.bvalid = 1'b0;
		// a read taken this cycle owns the store port, so a ready write waits one cycle
		do_read = arvalid && s_r.arready;
		do_write = s_r.aw_hold && s_r.w_hold && !s_r.bvalid && !do_read;
		if (do_write) begin
			s_nxt.aw_hold = 1'b0;
			s_nxt.w_hold = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = mapped(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end
		s_nxt.awready = !s_nxt.aw_hold && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_hold && !s_nxt.bvalid;

		// read channel: the store needs one cycle, so every read takes two
		if (do_read) begin
			s_nxt.rd_pend = 1'b1;
			s_nxt.rd_addr = araddr;
			s_nxt.arready = 1'b0;
		end
		if (s_r.rd_pend) begin
			s_nxt.rd_pend = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = mapped(s_r.rd_addr) ? RESP_OKAY : RESP_SLVERR;
			case (s_r.rd_addr)
				OFS_COUNT: s_nxt.rdata = s_r.count;
				OFS_MATCH0: s_nxt.rdata = s_r.match0;
				OFS_MATCH1: s_nxt.rdata = s_r.match1;
				OFS_LOAD: s_nxt.rdata = s_r.load;
				OFS_CTL: s_nxt.rdata = s_r.ctl;
				OFS_MASK: s_nxt.rdata = {{(32-EV_W){1'b0}}, s_r.mask};
				OFS_RAW: s_nxt.rdata = {{(32-EV_W){1'b0}}, s_r.raw};
				OFS_MASKED: s_nxt.rdata = {{(32-EV_W){1'b0}}, s_r.raw & s_r.mask};
				OFS_TRIM: s_nxt.rdata = s_r.trim;
				OFS_PINS: begin
					s_nxt.rdata = '0;
					s_nxt.rdata[PIN_WAKE] = wake_n;
					s_nxt.rdata[PIN_CUT] = power_cut_in;
					s_nxt.rdata[PIN_ASLEEP] = (s_r.pwr == BBS_CUT);
				end
				default: s_nxt.rdata = in_mem(s_r.rd_addr) ? mem_bus.rdata : '0;
			endcase
		end
		if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
			s_nxt.arready = 1'b1;
		end

		// slow reference: direct tick, or crystal divided down
		// reference select
		if (s_r.ctl[CTL_CLKEN] && !s_r.ctl[CTL_REFSEL] && xtal_tick)
			s_nxt.xdiv = s_r.xdiv + 1'b1;
		ref_pulse = s_r.ctl[CTL_CLKEN] &&
			(s_r.ctl[CTL_REFSEL] ? ref_tick : (xtal_tick && s_r.xdiv == XDIV_LAST));

		// predivider with trim
		// the divider keeps running while stopped, so a later start stays in phase
		sec_pulse = ref_pulse && (s_r.prediv == '0);
		if (ref_pulse) begin
			if (s_r.prediv == '0) begin
				s_nxt.sec_idx = s_r.sec_idx + 1'b1;
				s_nxt.prediv = (s_nxt.sec_idx == '0) ? s_r.trim[PRE_W-1:0] : PRE_NOMINAL;
			end else begin
				s_nxt.prediv = s_r.prediv - 1'b1;
			end
		end

		if (sec_pulse && s_r.ctl[CTL_RUN])
			s_nxt.count = s_r.count + 1'b1;

		// register writes; a load write wins over the same-cycle tick
		if (do_write && mapped(s_r.aw_addr)) begin
			wr_val = s_r.w_data;
			case (s_r.aw_addr)
				OFS_MATCH0: s_nxt.match0 = merge(s_r.match0, wr_val, s_r.w_strb);
				OFS_MATCH1: s_nxt.match1 = merge(s_r.match1, wr_val, s_r.w_strb);
				OFS_LOAD: begin
					s_nxt.load = merge(s_r.load, wr_val, s_r.w_strb);
					s_nxt.count = s_nxt.load;
				end
				OFS_CTL: s_nxt.ctl = (s_r.ctl & ~CTL_WMASK) |
					(merge(s_r.ctl, wr_val, s_r.w_strb) & CTL_WMASK);
				OFS_MASK: if (s_r.w_strb[0]) s_nxt.mask = wr_val[EV_W-1:0];
				OFS_CLEAR: if (s_r.w_strb[0]) ev_clr = wr_val[EV_W-1:0];
				OFS_TRIM: s_nxt.trim = merge(s_r.trim, wr_val, s_r.w_strb);
				default: s_nxt.ctl = s_nxt.ctl;
			endcase
		end

		eq_now[0] = (s_r.count == s_r.match0);
		eq_now[1] = (s_r.count == s_r.match1);
		s_nxt.eq_prev = eq_now;
		ev_set[EV_MATCH0] = eq_now[0] && !s_r.eq_prev[0];
		ev_set[EV_MATCH1] = eq_now[1] && !s_r.eq_prev[1];

		batt_low_now = vbat_low && (s_r.pwr == BBS_AWAKE);
		ev_set[EV_LOW_BATT_FLAG] = batt_low_now && s_r.ctl[CTL_LOW_BATT_FLAG];

		// pin assertion is the low level of the active-low wake input; the pin event is its falling edge
		wake_asserted = !wake_n;
		s_nxt.wake_prev = wake_n;
		ev_set[EV_PIN] = !wake_n && s_r.wake_prev;

		// flags are sticky across the wake
		s_nxt.raw = (s_r.raw & ~ev_clr) | ev_set;

		// power sequencing
		case (s_r.pwr)
			BBS_AWAKE: begin
				if (s_r.ctl[CTL_REQ]) begin
					s_nxt.ctl[CTL_REQ] = 1'b0;
					if (s_r.ctl[CTL_ABORT] && s_r.ctl[CTL_LOW_BATT_FLAG] && batt_low_now)
						s_nxt.pwr = BBS_AWAKE;
					// request without a wake source is dropped
					else if (s_r.ctl[CTL_PINWAKE] || s_r.ctl[CTL_MATCHWAKE])
						s_nxt.pwr = BBS_CUT;
				end
			end
			BBS_CUT: begin
				if ((s_r.ctl[CTL_PINWAKE] && wake_asserted) ||
					(s_r.ctl[CTL_MATCHWAKE] && (|eq_now)))
					s_nxt.pwr = BBS_AWAKE;
			end
			default: s_nxt.pwr = BBS_AWAKE;
		endcase

		// drive low while cut
		// open-drain: enable low only while pulling the line down
		s_nxt.cut_n = (s_nxt.pwr == BBS_AWAKE);
		s_nxt.cut_oe_n = (s_nxt.pwr == BBS_AWAKE);

		// line is OR of masked bits
		s_nxt.irq = |(s_nxt.raw & s_nxt.mask);

		if (sys_reset_req && !s_r.ctl[CTL_RUN] && !s_r.ctl[CTL_PINWAKE])
			s_nxt = STATE_RST;
	end

	assign mem_bus.en = do_read || do_write;
	assign mem_bus.we = do_write && in_mem(s_r.aw_addr);
	assign mem_bus.addr = do_write ? mem_index(s_r.aw_addr) : mem_index(araddr);
	assign mem_bus.wdata = s_r.w_data;
	assign mem_bus.strb = s_r.w_strb;

	bbs_mem u_mem (
		.clock(clock),
		.rst_b(rst_b),
		.ce(ce),
		.port(mem_bus.mem)
	);

	// all state in one register; clock enable freezes it
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			s_r <= STATE_RST;
		else if (ce)
			s_r <= s_nxt;
	end

	assign power_cut_out_n = s_r.cut_n;
	assign power_cut_oe_n = s_r.cut_oe_n;
	assign irq = s_r.irq;
	assign awready = s_r.awready;
	assign wready = s_r.wready;
	assign bresp = s_r.bresp;
	assign bvalid = s_r.bvalid;
	assign arready = s_r.arready;
	assign rdata = s_r.rdata;
	assign rresp = s_r.rresp;
	assign rvalid = s_r.rvalid;
endmodule
`default_nettype wire

// ---- sim/bbs_checker.sv ----
// Purpose: port-level checks for the sleep controller
// Assumes: one clock, rst_b asynchronous and active low
// Notes: bound into bbs_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module bbs_checker
	import bbs_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic power_cut_out_n,
	input wire logic power_cut_oe_n,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// level and driver enable of the cut pin must agree
	cut_pair_a: assert property (power_cut_out_n == power_cut_oe_n)
		else $error("cut level and enable differ");
	// a cut falls at the edge after the one that raised the write answer
	cut_cause_a: assert property ($fell(power_cut_out_n) |-> $past(bvalid))
		else $error("cut without a control write");
	// read answer two edges after the take
	read_lat_a: assert property (arvalid && arready |=> !arready ##1 rvalid)
		else $error("read answer late");
	// write answer two edges after both halves taken, one more if a read takes the store port
	write_lat_a: assert property (awvalid && awready && wvalid && wready |=>
		(!(arvalid && arready) ##1 bvalid) or (arvalid && arready ##2 bvalid))
		else $error("write answer late");
	// no new write taken while a response waits
	write_busy_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken during response");
	// no new read taken while data waits
	read_busy_a: assert property (rvalid |-> !arready)
		else $error("read taken during data");
	// hole in the map answers with an error and zero
	hole_err_a: assert property (arvalid && arready && araddr == 12'h02c |=> ##1
		rvalid && rresp == RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	// clear register reads as zero
	clear_zero_a: assert property (arvalid && arready && araddr == OFS_CLEAR |=> ##1 rdata == 32'h0)
		else $error("clear register read nonzero");
endmodule
bind bbs_top bbs_checker u_bbs_checker (.clock, .rst_b, .power_cut_out_n, .power_cut_oe_n, .araddr,
	.arvalid, .arready, .rdata, .rresp, .rvalid, .awvalid, .awready, .wvalid, .wready, .bvalid);
`default_nettype wire

// ---- sim/bbs_regulator.sv ----
// Purpose: external regulator and wake source facing the cut pin
// Assumes: cut line is open drain with a pull-up
// Notes: wake source only ever pulls the pin low
`timescale 1ns/1ps
`default_nettype none
module bbs_regulator (
	input wire logic power_cut_out_n,
	input wire logic power_cut_oe_n,
	input wire logic wake_cmd,
	output logic power_cut_in,
	output logic wake_n,
	output logic reg_on
);
	// released line floats to the pull-up level, not the last value
	assign power_cut_in = power_cut_oe_n ? 1'h1 : power_cut_out_n;
	// regulator enable follows the line
	assign reg_on = power_cut_in;
	// wake pin pulled up, driven low on command
	assign wake_n = !wake_cmd;
endmodule
`default_nettype wire

// ---- sim/bbs_top_bench.sv ----
// Purpose: self-checking bench for the sleep controller
// Assumes: reference tick every cycle so a second is short enough
// Notes: crystal tick and clock enable are held constant
`timescale 1ns/1ps
`default_nettype none
module bbs_top_bench
	import bbs_pkg::*;
;
	logic clock = 1'h0, rst_b = 1'h0, ce = 1'h1, sys_reset_req = 1'h0, ref_tick = 1'h0;
	logic xtal_tick = 1'h0, vbat_low = 1'h0, wake_cmd = 1'h0, tick_on = 1'h0;
	logic [ADDR_W-1:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, v, l;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic power_cut_out_n, power_cut_oe_n, irq, awready, wready, bvalid, arready, rvalid;
	logic wake_n, power_cut_in, reg_on;
	logic [1:0] bresp, rresp, r;
	logic [11:0] mem_a [4];
	logic [31:0] mem_d [4];
	int failures = 0, n_tests = 0, seed = 54, i;

	bbs_top u_bbs_top (.clock, .rst_b, .ce, .sys_reset_req, .ref_tick, .xtal_tick, .wake_n, .vbat_low,
		.power_cut_in, .power_cut_out_n, .power_cut_oe_n, .irq, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready);
	bbs_regulator u_bbs_regulator (.power_cut_out_n, .power_cut_oe_n, .wake_cmd, .power_cut_in,
		.wake_n, .reg_on);

	// 200 MHz clock
	always #2.5 clock = ~clock;
	// reference pulse on every edge while enabled
	always @(posedge clock) ref_tick <= tick_on;

	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", s, exp, seen);
		end
	endtask
	// accesses spaced apart
	// write: offer both halves, release each when taken, wait for response
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (!(bvalid && bready));
		r = bresp;
		bready <= 1'h0;
	endtask
	task rd(input logic [11:0] a);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (!rvalid);
		v = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	task rc(input string s, input logic [11:0] a, input logic [31:0] exp);
		rd(a);
		chk(s, v, exp);
	endtask
	// waits bounded well past one second of reference ticks
	task wait_on(input logic want_irq);
		i = 0;
		while (!(want_irq ? irq : reg_on) && i < 70000) begin
			@(posedge clock);
			i++;
		end
	endtask
	task complete_run;
		if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// watchdog sized for two seconds of ticks plus margin, kept under the run limit
	initial begin
		#(5 * 90000);
		failures++;
		complete_run;
	end

	// main sequence
	initial begin
		repeat (8) @(posedge clock);
		rst_b <= 1'h1;
		rc("count rst", OFS_COUNT, 32'h0);
		rc("match0 rst", OFS_MATCH0, 32'hffff_ffff);
		rc("match1 rst", OFS_MATCH1, 32'hffff_ffff);
		rc("load rst", OFS_LOAD, 32'hffff_ffff);
		rc("ctl rst", OFS_CTL, 32'h8000_0000);
		rc("mask rst", OFS_MASK, 32'h0);
		rc("raw rst", OFS_RAW, 32'h0);
		rc("trim rst", OFS_TRIM, 32'h0000_7fff);
		// random words into storage registers and retained store
		for (i = 1; i < 4; i++) begin
			l = $random(seed);
			wr(12'(4 * i), l);
			rc("rw reg", 12'(4 * i), l);
		end
		for (i = 0; i < 4; i++) begin
			l = $random(seed);
			mem_a[i] = 12'h030 + 12'(64 * i) + {6'h0, l[3:0], 2'h0};
			mem_d[i] = $random(seed);
			wr(mem_a[i], mem_d[i]);
			rc("store", mem_a[i], mem_d[i]);
		end
		wr(OFS_MASK, 32'h3);
		rc("mask", OFS_MASK, 32'h3);
		wr(12'h02c, 32'h0);
		chk("wr hole", {30'h0, r}, 32'h2);
		rc("rd hole", 12'h02c, 32'h0);
		chk("rd hole resp", {30'h0, r}, 32'h2);
		rc("clear rd", OFS_CLEAR, 32'h0);
		wr(OFS_TRIM, 32'h0000_7ffe);
		rc("trim rw", OFS_TRIM, 32'h0000_7ffe);
		// one second of counting onto both comparators
		l = $random(seed);
		wr(OFS_LOAD, l);
		rc("count load", OFS_COUNT, l);
		wr(OFS_MATCH0, l + 32'h1);
		wr(OFS_MATCH1, l + 32'h1);
		wr(OFS_MASK, 32'h1);
		tick_on <= 1'h1;
		wr(OFS_CTL, 32'h45);
		wait_on(1'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		rc("count", OFS_COUNT, l + 32'h1);
		rc("raw match", OFS_RAW, 32'h3);
		rc("masked", OFS_MASKED, 32'h1);
		wr(OFS_CLEAR, 32'h3);
		rc("raw clr", OFS_RAW, 32'h0);
		chk("irq clr", {31'h0, irq}, 32'h0);
		// request without a wake source is refused
		wr(OFS_CTL, 32'h42);
		repeat (3) @(posedge clock);
		chk("no wake", {31'h0, reg_on}, 32'h1);
		rc("ctl req clr", OFS_CTL, 32'h8000_0040);
		// low battery with abort keeps power on
		vbat_low <= 1'h1;
		wr(OFS_CTL, 32'hf6);
		repeat (3) @(posedge clock);
		chk("abort", {31'h0, reg_on}, 32'h1);
		rc("raw low_batt_flag", OFS_RAW, 32'h4);
		vbat_low <= 1'h0;
		wr(OFS_CLEAR, 32'hf);
		// pin wake, battery low only while down
		wr(OFS_CTL, 32'h76);
		repeat (3) @(posedge clock);
		chk("cut pin", {31'h0, reg_on}, 32'h0);
		vbat_low <= 1'h1;
		repeat (4) @(posedge clock);
		vbat_low <= 1'h0;
		wake_cmd <= 1'h1;
		repeat (3) @(posedge clock);
		chk("pin wake", {31'h0, reg_on}, 32'h1);
		wake_cmd <= 1'h0;
		rc("raw pin", OFS_RAW, 32'h8);
		rc("ctl kept", OFS_CTL, 32'h8000_0074);
		// match wake while the counter keeps counting up
		wr(OFS_CLEAR, 32'hf);
		l = $random(seed);
		wr(OFS_LOAD, l);
		wr(OFS_MATCH0, l + 32'h1);
		wr(OFS_CTL, 32'h4f);
		repeat (3) @(posedge clock);
		chk("cut match", {31'h0, reg_on}, 32'h0);
		wait_on(1'h0);
		chk("match wake", {31'h0, reg_on}, 32'h1);
		rc("raw wake", OFS_RAW, 32'h1);
		// system reset ignored while counting, honoured after
		for (i = 0; i < 2; i++) begin
			if (i == 1) wr(OFS_CTL, 32'h44);
			@(posedge clock);
			sys_reset_req <= 1'h1;
			@(posedge clock);
			sys_reset_req <= 1'h0;
			rc("sysrst", OFS_MATCH0, i ? 32'hffff_ffff : l + 32'h1);
		end
		for (i = 0; i < 4; i++) rc("store kept", mem_a[i], mem_d[i]);
		complete_run;
	end
endmodule
`default_nettype wire
